// ---- src/egp_top.sv ----
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps

// Operation
// - eight pins, each with its own direction bit and output latch bit.
// - direction 0 drives the latch onto the pin, 1 makes it an input.
// - general-purpose inputs use the Schmitt-trigger input buffer.
// - every reset returns all pins to digital inputs.
// - weak pull-up per pin; the global disable bit turns all eight off.
// - a pin configured as output has its pull-up switched off.
// - pull-ups are disabled after every reset.
// - the external bus shares the pins only on the large-package variant.
// - general I/O and other functions exist only while the bus is disabled.
// - enabled external bus uses the pins as address/data low byte, overriding direction.
// - slave-port select runs the port as parallel slave port with TTL buffers.
// - parallel slave port works only when the external bus is not in use.
// - second serial module uses pins 4, 5 and 6.
// - serial open-drain bit makes the serial output pins open-drain.
// - pulse output on pin 0; timer5 clock and timer7 gate inputs on pin 1.
// - an alternate function owning a pin ignores or overrides its direction bit.
module egp_top #(
    parameter bit LARGE_PACKAGE = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_pullup_en,
    output logic [7:0] pin_ttl_sel,
    input wire logic [7:0] ebus_ad_out,
    input wire logic ebus_ad_oe,
    output logic [7:0] ebus_ad_in,
    output logic ebus_active,
    input wire logic [7:0] psp_data_out,
    input wire logic psp_data_oe,
    output logic [7:0] psp_data_in,
    output logic psp_active,
    input wire logic ser_en,
    input wire logic [2:0] ser_out,
    input wire logic [2:0] ser_oe,
    output logic [2:0] ser_in,
    input wire logic pulse_en,
    input wire logic pulse_gen_output,
    input wire logic timer_in_en,
    output logic timer5_clock_input,
    output logic timer7_gate_input
);

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] port_output_latch;
    logic [7:0] port_direction;
    logic [7:0] pad_config_reg;
    logic [7:0] memory_ctrl_reg;
    logic [7:0] port_e_direction;
    logic [7:0] open_drain_ctrl_reg;
    logic [7:0] next_port_output_latch;
    logic [7:0] next_port_direction;
    logic [7:0] next_pad_config_reg;
    logic [7:0] next_memory_ctrl_reg;
    logic [7:0] next_port_e_direction;
    logic [7:0] next_open_drain_ctrl_reg;
    logic ph_valid;
    logic ph_write;
    logic [31:0] ph_addr;
    logic next_ph_valid;
    logic next_ph_write;
    logic [31:0] next_ph_addr;
    logic [31:0] next_hrdata;
    logic [7:0] next_pin_out;
    logic [7:0] next_pin_oe;
    logic [7:0] next_pin_pullup_en;
    logic [7:0] next_pin_ttl_sel;
    logic [7:0] pin_sync;
    logic [7:0] gpio_own;
    logic [7:0] out_cfg;
    logic [7:0] ser_out8;
    logic [7:0] ser_oe8;
    logic ser_own;
    logic global_pullup_disable;
    logic serial2_open_drain;
    logic addr_take;
    egp_pkg::egp_owner_t own [8];

    function automatic logic egp_hit(input logic [31:0] a, input logic [7:0] off);
        egp_hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
    endfunction

    // ************************************************************
    // input synchroniser
    // ************************************************************
    egp_sync #(
        .WIDTH(8)
    ) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .d(pin_in),
        .q(pin_sync)
    );

    // synchronised levels feed software and alternate inputs alike
    assign ebus_ad_in = pin_sync;
    assign psp_data_in = pin_sync;
    assign ser_in = pin_sync[egp_pkg::PIN_SERIAL_HI:egp_pkg::PIN_SERIAL_LO];
    assign timer5_clock_input = pin_sync[egp_pkg::PIN_TIMER];
    assign timer7_gate_input = pin_sync[egp_pkg::PIN_TIMER];

    // ************************************************************
    // bus slave, zero wait states
    // ************************************************************
    // every transfer finishes in one data-phase cycle, so no stall logic
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_take = hsel && hready && htrans[1];

    // register updates; read data is built from next values so a read
    // right behind a write already sees the new contents
    always_comb begin
        next_port_output_latch = port_output_latch;
        next_port_direction = port_direction;
        next_pad_config_reg = pad_config_reg;
        next_memory_ctrl_reg = memory_ctrl_reg;
        next_port_e_direction = port_e_direction;
        next_open_drain_ctrl_reg = open_drain_ctrl_reg;
        if (ph_valid && ph_write) begin
            if (egp_hit(ph_addr, egp_pkg::OFF_PIN_VALUE) || egp_hit(ph_addr, egp_pkg::OFF_OUTPUT_LATCH)) begin
                next_port_output_latch = hwdata[7:0];
            end
            if (egp_hit(ph_addr, egp_pkg::OFF_DIRECTION)) begin
                next_port_direction = hwdata[7:0];
            end
            if (egp_hit(ph_addr, egp_pkg::OFF_PAD_CONFIG)) begin
                next_pad_config_reg = hwdata[7:0];
            end
            if (egp_hit(ph_addr, egp_pkg::OFF_MEMORY_CTRL)) begin
                next_memory_ctrl_reg = hwdata[7:0];
            end
            if (egp_hit(ph_addr, egp_pkg::OFF_PORT_E_DIR)) begin
                next_port_e_direction = hwdata[7:0];
            end
            if (egp_hit(ph_addr, egp_pkg::OFF_OPEN_DRAIN)) begin
                next_open_drain_ctrl_reg = hwdata[7:0];
            end
        end
        if (!rstn) begin
            next_port_output_latch = egp_pkg::RST_OUTPUT_LATCH;
            next_port_direction = egp_pkg::RST_DIRECTION;
            next_pad_config_reg = egp_pkg::RST_PAD_CONFIG;
            next_memory_ctrl_reg = egp_pkg::RST_MEMORY_CTRL;
            next_port_e_direction = egp_pkg::RST_PORT_E_DIR;
            next_open_drain_ctrl_reg = egp_pkg::RST_OPEN_DRAIN;
        end
    end

    // address phase capture and read mux; unmapped reads give zero
    always_comb begin
        next_ph_valid = rstn && addr_take;
        next_ph_write = rstn && hwrite;
        next_ph_addr = rstn ? haddr : 32'h00000000;
        next_hrdata = 32'h00000000;
        if (rstn && addr_take && !hwrite) begin
            if (egp_hit(haddr, egp_pkg::OFF_PIN_VALUE)) begin
                next_hrdata[7:0] = pin_sync;
            end
            if (egp_hit(haddr, egp_pkg::OFF_OUTPUT_LATCH)) begin
                next_hrdata[7:0] = next_port_output_latch;
            end
            if (egp_hit(haddr, egp_pkg::OFF_DIRECTION)) begin
                next_hrdata[7:0] = next_port_direction;
            end
            if (egp_hit(haddr, egp_pkg::OFF_PAD_CONFIG)) begin
                next_hrdata[7:0] = next_pad_config_reg;
            end
            if (egp_hit(haddr, egp_pkg::OFF_MEMORY_CTRL)) begin
                next_hrdata[7:0] = next_memory_ctrl_reg;
            end
            if (egp_hit(haddr, egp_pkg::OFF_PORT_E_DIR)) begin
                next_hrdata[7:0] = next_port_e_direction;
            end
            if (egp_hit(haddr, egp_pkg::OFF_OPEN_DRAIN)) begin
                next_hrdata[7:0] = next_open_drain_ctrl_reg;
            end
        end
    end

    // register file and bus phase
    always_ff @(posedge ref_clk) begin
        port_output_latch <= next_port_output_latch;
        port_direction <= next_port_direction;
        pad_config_reg <= next_pad_config_reg;
        memory_ctrl_reg <= next_memory_ctrl_reg;
        port_e_direction <= next_port_e_direction;
        open_drain_ctrl_reg <= next_open_drain_ctrl_reg;
        ph_valid <= next_ph_valid;
        ph_write <= next_ph_write;
        ph_addr <= next_ph_addr;
        hrdata <= next_hrdata;
    end

    // ************************************************************
    // pin ownership and pad drive
    // ************************************************************
    // the bus mode is fixed off on the small package
    assign ebus_active = LARGE_PACKAGE && !memory_ctrl_reg[egp_pkg::BIT_EXT_BUS_DISABLE];
    assign psp_active = port_e_direction[egp_pkg::BIT_SLAVE_PORT_SELECT] && !ebus_active;
    assign global_pullup_disable = pad_config_reg[egp_pkg::BIT_PULLUP_DISABLE];
    assign serial2_open_drain = open_drain_ctrl_reg[egp_pkg::BIT_SERIAL2_OPEN_DRAIN];
    assign ser_out8 = {1'b0, ser_out, 4'h0};
    assign ser_oe8 = {1'b0, ser_oe, 4'h0};
    assign ser_own = !ebus_active && !psp_active && ser_en;

    // priority: bus, slave port, serial, pulse/timer, then plain I/O
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (ebus_active) begin
                own[i] = egp_pkg::OWN_EBUS;
            end else if (psp_active) begin
                own[i] = egp_pkg::OWN_PSP;
            end else if (ser_en && i >= egp_pkg::PIN_SERIAL_LO && i <= egp_pkg::PIN_SERIAL_HI) begin
                own[i] = egp_pkg::OWN_SERIAL;
            end else if (pulse_en && i == egp_pkg::PIN_PULSE) begin
                own[i] = egp_pkg::OWN_PULSE;
            end else if (timer_in_en && i == egp_pkg::PIN_TIMER) begin
                own[i] = egp_pkg::OWN_TIMER;
            end else begin
                own[i] = egp_pkg::OWN_GPIO;
            end
        end
    end

    // per-pin drive; an owner other than plain I/O never looks at the direction bit
    always_comb begin
        next_pin_out = 8'h00;
        next_pin_oe = 8'h00;
        next_pin_pullup_en = 8'h00;
        out_cfg = 8'h00;
        gpio_own = 8'h00;
        for (int i = 0; i < 8; i++) begin
            case (own[i])
                egp_pkg::OWN_GPIO: begin
                    gpio_own[i] = 1'b1;
                    out_cfg[i] = !port_direction[i];
                    next_pin_out[i] = port_output_latch[i];
                    next_pin_oe[i] = !port_direction[i];
                end
                egp_pkg::OWN_EBUS: begin
                    out_cfg[i] = ebus_ad_oe;
                    next_pin_out[i] = ebus_ad_out[i];
                    next_pin_oe[i] = ebus_ad_oe;
                end
                egp_pkg::OWN_PSP: begin
                    out_cfg[i] = psp_data_oe;
                    next_pin_out[i] = psp_data_out[i];
                    next_pin_oe[i] = psp_data_oe;
                end
                egp_pkg::OWN_SERIAL: begin
                    out_cfg[i] = ser_oe8[i];
                    next_pin_out[i] = ser_out8[i];
                    // open-drain only sinks; the pad never drives a high level
                    next_pin_oe[i] = ser_oe8[i] && !(serial2_open_drain && ser_out8[i]);
                end
                egp_pkg::OWN_PULSE: begin
                    out_cfg[i] = 1'b1;
                    next_pin_out[i] = pulse_gen_output;
                    next_pin_oe[i] = 1'b1;
                end
                egp_pkg::OWN_TIMER: begin
                    out_cfg[i] = 1'b0;
                end
                default: begin
                    out_cfg[i] = 1'b0;
                end
            endcase
            next_pin_pullup_en[i] = !global_pullup_disable && !out_cfg[i];
        end
        // TTL buffers for bus and slave port, Schmitt otherwise
        next_pin_ttl_sel = (ebus_active || psp_active) ? 8'hff : 8'h00;
        if (!rstn) begin
            next_pin_out = 8'h00;
            next_pin_oe = 8'h00;
            next_pin_pullup_en = 8'h00;
            next_pin_ttl_sel = 8'h00;
        end
    end

    // pad outputs are registered to keep glitches off the pins
    always_ff @(posedge ref_clk) begin
        pin_out <= next_pin_out;
        pin_oe <= next_pin_oe;
        pin_pullup_en <= next_pin_pullup_en;
        pin_ttl_sel <= next_pin_ttl_sel;
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_reset_inputs: assert property (disable iff (1'b0) !rstn |=> pin_oe == 8'h00)
        else $error("pins not inputs after reset");
    a_reset_pullups: assert property (disable iff (1'b0) !rstn |=> pin_pullup_en == 8'h00)
        else $error("pull-ups on after reset");
    a_dir_drive: assert property ($past(rstn) |-> (pin_oe & $past(gpio_own)) == $past(~port_direction & gpio_own))
        else $error("pin drive does not follow direction");
    a_latch_value: assert property ($past(rstn) |-> (pin_out & $past(gpio_own & ~port_direction))
        == $past(port_output_latch & gpio_own & ~port_direction))
        else $error("driven pin differs from latch");
    a_pullup_global: assert property ($past(rstn) && $past(global_pullup_disable) |-> pin_pullup_en == 8'h00)
        else $error("pull-up on while globally disabled");
    a_pullup_output: assert property ((pin_pullup_en & pin_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    a_ebus_own: assert property ($past(rstn) && $past(ebus_active) |-> pin_oe == {8{$past(ebus_ad_oe)}}
        && pin_ttl_sel == 8'hff)
        else $error("bus does not own the pins");
    a_psp_excl: assert property (!(psp_active && ebus_active) && (!ebus_active || LARGE_PACKAGE))
        else $error("slave port with external bus");
    a_buffer_kind: assert property ($past(rstn) && $past(psp_active) != $past(ebus_active) |-> pin_ttl_sel == 8'hff)
        else $error("slave port not on ttl buffers");
    a_schmitt_gpio: assert property ($past(rstn) && !$past(psp_active) && !$past(ebus_active)
        |-> pin_ttl_sel == 8'h00)
        else $error("gpio not on schmitt buffers");
    a_od_serial: assert property ($past(rstn) && $past(ser_own && serial2_open_drain)
        |-> (pin_oe[6:4] & pin_out[6:4]) == 3'h0)
        else $error("open-drain pin driven high");
    a_pulse_pin: assert property ($past(rstn) && $past(own[0] == egp_pkg::OWN_PULSE)
        |-> pin_oe[0] && pin_out[0] == $past(pulse_gen_output))
        else $error("pulse output not on pin 0");
    a_write_latch: assert property (ph_valid && ph_write && rstn && (egp_hit(ph_addr, egp_pkg::OFF_PIN_VALUE)
        || egp_hit(ph_addr, egp_pkg::OFF_OUTPUT_LATCH)) |=> port_output_latch == $past(hwdata[7:0]))
        else $error("latch not loaded by write");
    a_read_pins: assert property (addr_take && !hwrite && egp_hit(haddr, egp_pkg::OFF_PIN_VALUE)
        |=> hrdata == {24'h000000, $past(pin_sync)})
        else $error("pin read wrong");
    a_sync_delay: assert property ($past(rstn) && $past(rstn, 2) |-> pin_sync == $past(pin_in, 2))
        else $error("synchroniser delay wrong");

    c_gpio_out: cover property (pin_oe[3] && gpio_own[3]);
    c_ebus_mode: cover property (ebus_active && ebus_ad_oe ##1 pin_oe == 8'hff);
    c_psp_mode: cover property (psp_active ##1 pin_ttl_sel == 8'hff);
    c_od_low: cover property (ser_own && serial2_open_drain ##1 pin_oe[5] && !pin_out[5]);

endmodule

// ---- src/egp_pkg.sv ----
package egp_pkg;

    // ************************************************************
    // register map, byte offsets of aligned 32-bit words
    // ************************************************************
    localparam logic [7:0] OFF_PIN_VALUE = 8'h00;
    localparam logic [7:0] OFF_OUTPUT_LATCH = 8'h04;
    localparam logic [7:0] OFF_DIRECTION = 8'h08;
    localparam logic [7:0] OFF_PAD_CONFIG = 8'h0c;
    localparam logic [7:0] OFF_MEMORY_CTRL = 8'h10;
    localparam logic [7:0] OFF_PORT_E_DIR = 8'h14;
    localparam logic [7:0] OFF_OPEN_DRAIN = 8'h18;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int BIT_PULLUP_DISABLE = 7;
    localparam int BIT_EXT_BUS_DISABLE = 7;
    localparam int BIT_SLAVE_PORT_SELECT = 4;
    localparam int BIT_SERIAL2_OPEN_DRAIN = 0;
    localparam int PIN_PULSE = 0;
    localparam int PIN_TIMER = 1;
    localparam int PIN_SERIAL_LO = 4;
    localparam int PIN_SERIAL_HI = 6;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'hff;
    localparam logic [7:0] RST_PAD_CONFIG = 8'h80;
    localparam logic [7:0] RST_MEMORY_CTRL = 8'h80;
    localparam logic [7:0] RST_PORT_E_DIR = 8'h07;
    localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;

    // ************************************************************
    // pin owner, one-hot
    // ************************************************************
    typedef enum logic [5:0] {
        OWN_GPIO = 6'h01,
        OWN_EBUS = 6'h02,
        OWN_PSP = 6'h04,
        OWN_SERIAL = 6'h08,
        OWN_PULSE = 6'h10,
        OWN_TIMER = 6'h20
    } egp_owner_t;

endpackage

// ---- src/egp_sync.sv ----
`timescale 1ns/100ps

// ************************************************************
// two-flop synchroniser for pad inputs
// ************************************************************
module egp_sync #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    // first stage feeds only the second stage
    always_comb begin
        next_meta = rstn ? d : '0;
        next_q = rstn ? meta : '0;
    end

    // register both stages
    always_ff @(posedge ref_clk) begin
        meta <= next_meta;
        q <= next_q;
    end

endmodule

// ---- testbench/egp_pin_model.sv ----
`timescale 1ns/100ps

// ************************************************************
// far-side pad model: outside drivers, pull-ups, floating lines
// ************************************************************
module egp_pin_model (
    input wire logic ref_clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup_en,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    logic [7:0] last = 8'h00;

    // device drive wins, then the outside driver, then the weak pull-up;
    // a floating pin toggles so a stale value can never pass for a read
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pin_pullup_en[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = ~last[i];
        end
    end

    // remember the level so a released line can move away from it
    always_ff @(posedge ref_clk) begin
        last <= pin_in;
    end
endmodule

// ---- testbench/eight_bit_gpio_port_test.sv ----
`timescale 1ns/100ps

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end

module eight_bit_gpio_port_test;
    logic ref_clk, rstn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, ser_out, ser_oe, ser_in;
    logic [7:0] pin_in, pin_out, pin_oe, pu, ttl, xen, xval, d;
    logic [7:0] ebus_ad_out, ebus_ad_in, psp_data_out, psp_data_in;
    logic ebus_ad_oe, ebus_active, psp_data_oe, psp_active, ser_en, pulse_en, pgo, tmr_en, t5, t7;
    int failures = 0;
    int n_compared = 0;

    egp_top #(.LARGE_PACKAGE(1'b1)) u_dut (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup_en(pu), .pin_ttl_sel(ttl), .ebus_ad_out(ebus_ad_out),
        .ebus_ad_oe(ebus_ad_oe), .ebus_ad_in(ebus_ad_in), .ebus_active(ebus_active),
        .psp_data_out(psp_data_out), .psp_data_oe(psp_data_oe), .psp_data_in(psp_data_in),
        .psp_active(psp_active), .ser_en(ser_en), .ser_out(ser_out), .ser_oe(ser_oe), .ser_in(ser_in),
        .pulse_en(pulse_en), .pulse_gen_output(pgo), .timer_in_en(tmr_en), .timer5_clock_input(t5),
        .timer7_gate_input(t7));

    egp_pin_model u_pins (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pu),
        .ext_en(xen), .ext_val(xval), .pin_in(pin_in));

    // ************************************************************
    // clock and closing report
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ************************************************************
    // bus master tasks
    // ************************************************************
    // waits for hready at a rising edge; a hung slave ends the run
    task automatic wt;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            failures++;
            end_sim();
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        wt();
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        wt();
        rd = hrdata[7:0];
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] wd);
        logic [7:0] x;
        xfer(a, 1'b1, wd, x);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        xfer(a, 1'b0, 8'h00, d);
        `CHK("read", e, d)
        `CHK("hresp", 1'b0, hresp)
    endtask

    // pad outputs land one edge after the register; pins need two more for sync
    task automatic ps;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rstn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
        ebus_ad_out = 8'h00; ebus_ad_oe = 1'b0; psp_data_out = 8'h00; psp_data_oe = 1'b0; ser_en = 1'b0;
        ser_out = 3'h0; ser_oe = 3'h0; pulse_en = 1'b0; pgo = 1'b0; tmr_en = 1'b0; xen = 8'hff; xval = 8'h00;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        // reset state: all inputs, pull-ups off, register table values
        ps();
        `CHK("oe", 8'h00, pin_oe)
        `CHK("pullup", 8'h00, pu)
        rchk(egp_pkg::OFF_OUTPUT_LATCH, egp_pkg::RST_OUTPUT_LATCH);
        rchk(egp_pkg::OFF_DIRECTION, egp_pkg::RST_DIRECTION);
        rchk(egp_pkg::OFF_PAD_CONFIG, egp_pkg::RST_PAD_CONFIG);
        rchk(egp_pkg::OFF_MEMORY_CTRL, egp_pkg::RST_MEMORY_CTRL);
        rchk(egp_pkg::OFF_PORT_E_DIR, egp_pkg::RST_PORT_E_DIR);
        rchk(egp_pkg::OFF_OPEN_DRAIN, egp_pkg::RST_OPEN_DRAIN);
        rchk(8'h1c, 8'h00);
        $display("test reset done");
        // mixed direction: latch via port write, pins read back through sync
        xval <= 8'h96;
        wr(egp_pkg::OFF_PIN_VALUE, 8'ha5);
        wr(egp_pkg::OFF_DIRECTION, 8'h0f);
        ps();
        `CHK("oe", 8'hf0, pin_oe)
        `CHK("out", 8'ha0, pin_out & 8'hf0)
        rchk(egp_pkg::OFF_PIN_VALUE, 8'ha6);
        wr(egp_pkg::OFF_OUTPUT_LATCH, 8'h3c);
        rchk(egp_pkg::OFF_OUTPUT_LATCH, 8'h3c);
        `CHK("ttl", 8'h00, ttl)
        $display("test direction done");
        // pull-ups on only for input pins, readable with nobody driving
        wr(egp_pkg::OFF_PAD_CONFIG, 8'h00);
        xen <= 8'h00;
        ps();
        `CHK("pullup", 8'h0f, pu)
        rchk(egp_pkg::OFF_PIN_VALUE, 8'h3f);
        wr(egp_pkg::OFF_PAD_CONFIG, 8'h80);
        xen <= 8'hff;
        ps();
        `CHK("pullup", 8'h00, pu)
        $display("test pullup done");
        // external bus owns the pins and overrides direction
        @(posedge ref_clk);
        ebus_ad_oe <= 1'b1;
        ebus_ad_out <= 8'h33;
        wr(egp_pkg::OFF_MEMORY_CTRL, 8'h00);
        ps();
        `CHK("ebus", 1'b1, ebus_active)
        `CHK("oe", 8'hff, pin_oe)
        `CHK("out", 8'h33, pin_out)
        `CHK("ebus_in", 8'h33, ebus_ad_in)
        wr(egp_pkg::OFF_PORT_E_DIR, 8'h17);
        ps();
        `CHK("psp", 1'b0, psp_active)
        @(posedge ref_clk);
        ebus_ad_oe <= 1'b0;
        wr(egp_pkg::OFF_MEMORY_CTRL, 8'h80);
        ps();
        `CHK("psp", 1'b1, psp_active)
        `CHK("ttl", 8'hff, ttl)
        `CHK("oe", 8'h00, pin_oe)
        `CHK("psp_in", 8'h96, psp_data_in)
        @(posedge ref_clk);
        psp_data_oe <= 1'b1;
        psp_data_out <= 8'hc3;
        ps();
        `CHK("out", 8'hc3, pin_out)
        @(posedge ref_clk);
        psp_data_oe <= 1'b0;
        wr(egp_pkg::OFF_PORT_E_DIR, 8'h07);
        $display("test alternate bus done");
        // serial pins, push-pull then open-drain
        ser_en <= 1'b1;
        ser_oe <= 3'h7;
        ser_out <= 3'h5;
        wr(egp_pkg::OFF_DIRECTION, 8'hff);
        ps();
        `CHK("ser_oe", 3'h7, pin_oe[6:4])
        `CHK("ser_out", 3'h5, pin_out[6:4])
        `CHK("ser_in", 3'h5, ser_in)
        wr(egp_pkg::OFF_OPEN_DRAIN, 8'h01);
        ps();
        `CHK("ser_oe", 3'h2, pin_oe[6:4])
        @(posedge ref_clk);
        ser_en <= 1'b0;
        // pulse on pin 0, timer inputs from pin 1 against direction bit 0
        pulse_en <= 1'b1;
        pgo <= 1'b1;
        tmr_en <= 1'b1;
        xval <= 8'h02;
        wr(egp_pkg::OFF_DIRECTION, 8'h00);
        ps();
        `CHK("pulse", 2'h1, {pin_oe[1], pin_oe[0]})
        `CHK("pulse_out", 1'b1, pin_out[0])
        `CHK("timers", 2'h3, {t5, t7})
        $display("test serial and timer done");
        // reset in mid-run returns every pin to input
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK("oe", 8'h00, pin_oe)
        `CHK("pullup", 8'h00, pu)
        @(posedge ref_clk);
        rstn <= 1'b1;
        rchk(egp_pkg::OFF_DIRECTION, egp_pkg::RST_DIRECTION);
        $display("test second reset done");
        end_sim();
    end
endmodule
